//--- rtl/asr_pkg.sv
// constants and types shared by the serial result port
// assumes a 25 MHz system clock and a 16-bit conversion result
package asr_pkg;
	localparam int RESULT_W     = 16;
	localparam int CLK_HZ       = 25_000_000;
	// conversion time, longest figure, rounds down to whole cycles
	localparam int CONVERT_STROBE_TIME_NS = 4000;
	localparam int CONVERT_STROBE_CYCLES  = (CONVERT_STROBE_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
	// internal serial clock half period in system cycles, at least 2
	localparam int SCLK_HALF    = 2;
	localparam int BUF_DEPTH    = 2;
	localparam logic BUSY_IDLE  = 1'b1;
	localparam logic SEL_MASTER = 1'b0;

	typedef enum {
		ASR_IDLE,
		ASR_CONVERT_STROBE
	} asr_state_e;
endpackage

//--- rtl/asr_buf.sv
// small flip-flop fifo with valid/ready on both sides
// assumes both sides on one clock; in_ready comes from a register
`timescale 1ns/1ps
module asr_buf #(
	parameter int W     = 16,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// filling side
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	// draining side
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [W-1:0]  mem_r [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] wr_ptr_nxt;
	logic [PW-1:0] rd_ptr_r;
	logic [PW-1:0] rd_ptr_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          room_r;
	logic          room_nxt;
	logic          push;
	logic          pop;

	assign in_ready  = room_r;
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rd_ptr_r];

	always_comb
	begin
		push       = in_valid && room_r;
		pop        = out_ready && (cnt_r != '0);
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		cnt_nxt    = cnt_r;
		if (push)
			wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
		if (pop)
			rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
		if (push && !pop)
			cnt_nxt = cnt_r + 1'b1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 1'b1;
		room_nxt = (cnt_nxt != FULL);
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
			room_r   <= 1'b1;
		end
		else
		begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			cnt_r    <= cnt_nxt;
			room_r   <= room_nxt;
		end
	end

	// storage has no reset; out_valid guards it
	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end
endmodule // asr_buf

//--- rtl/asr_result_port.sv
// serial result port of a sampling converter, master or slave clocking
// assumes a converter core on clk handing in results; pins are async
//
// Function
// R1 - select low: device drives serial clock itself; high: host clocks it.
// R2 - master mode: host uses busy as its slave select.
// R3 - busy falling starts conversion and shifting of the previous result.
// R4 - master serial clock idles low; data steady around both clock edges.
// R5 - convert strobe may come from a trigger or from the host.
// R6 - master mode: host is a 16-bit spi slave, only peripheral.
// R7 - slave mode: each bit launched on the host clock's rising edge.
// R8 - slave mode: host idles clock low and samples on falling edges.
// R9 - host may sample on rising edges only with 17 or more clocks.
// R10 - read after busy falls returns previous result during conversion.
// R11 - such a read must finish all 16 bits before busy rises.
// R12 - preferred: static clock during conversion, read after busy rises.
// R13 - 8-bit hosts use slave mode and two 8-bit transfers.
// R14 - first 8-bit transfer carries the upper byte, second the rest.
// R15 - results shift out msb first, one bit per serial clock.
`timescale 1ns/1ps
module asr_result_port #(
	parameter int RESULT_W    = asr_pkg::RESULT_W,
	parameter int CONVERT_STROBE_CYCLES = asr_pkg::CONVERT_STROBE_CYCLES,
	parameter int SCLK_HALF   = asr_pkg::SCLK_HALF,
	parameter int BUF_DEPTH   = asr_pkg::BUF_DEPTH
) (
	// system clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// results from the converter core
	input  wire logic [RESULT_W-1:0] result_data,
	input  wire logic                result_valid,
	output logic                     result_ready,
	output logic                     convert_strobe_start,
	// control pins
	input  wire logic                clock_source_select,
	input  wire logic                convert_strobe_n,
	output logic                     busy,
	// serial pins
	output logic                     serial_result_out,
	input  wire logic                sclk_i,
	output logic                     sclk_o,
	output logic                     sclk_oe
);
	localparam int CCW = $clog2(CONVERT_STROBE_CYCLES + 1);
	localparam int PHW = $clog2(2 * SCLK_HALF);
	localparam int BW  = $clog2(RESULT_W + 1);
	localparam logic [CCW-1:0] CONVERT_STROBE_LAST = CCW'(CONVERT_STROBE_CYCLES - 1);
	localparam logic [PHW-1:0] PH_HIGH   = PHW'(SCLK_HALF);
	localparam logic [PHW-1:0] PH_LAST   = PHW'(2 * SCLK_HALF - 1);
	localparam logic [PHW-1:0] PH_MID    = PHW'(SCLK_HALF / 2);
	localparam logic [BW-1:0]  BIT_LAST  = BW'(RESULT_W - 1);
	localparam logic [BW-1:0]  BIT_ALL   = BW'(RESULT_W);

	// pin synchronisers
	logic sel_s1_r;
	logic sel_s2_r;
	logic cnv_s1_r;
	logic cnv_s2_r;
	logic cnv_d_r;

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sel_s1_r <= asr_pkg::SEL_MASTER;
			sel_s2_r <= asr_pkg::SEL_MASTER;
			cnv_s1_r <= 1'b1;
			cnv_s2_r <= 1'b1;
			cnv_d_r  <= 1'b1;
		end
		else
		begin
			sel_s1_r <= clock_source_select;
			sel_s2_r <= sel_s1_r;
			cnv_s1_r <= convert_strobe_n;
			cnv_s2_r <= cnv_s1_r;
			cnv_d_r  <= cnv_s2_r;
		end
	end

	logic mode_slave;
	logic strobe_fall;

	assign mode_slave  = (sel_s2_r != asr_pkg::SEL_MASTER); // R1
	// strobe source does not matter; only its falling edge counts
	assign strobe_fall = cnv_d_r && !cnv_s2_r; // R5

	// result buffer: drained only at conversion end, so without convert
	// strobes a full buffer stalls the core through result_ready
	logic [RESULT_W-1:0] buf_data;
	logic                buf_valid;
	logic                buf_pop;
	logic                buf_in_ready;

	asr_buf #(
		.W     (RESULT_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_data   (result_data),
		.in_valid  (result_valid),
		.in_ready  (buf_in_ready),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (buf_pop)
	);

	assign result_ready = buf_in_ready;

	// conversion sequencing
	asr_pkg::asr_state_e state_r;
	asr_pkg::asr_state_e state_nxt;
	logic [CCW-1:0]      ccnt_r;
	logic [CCW-1:0]      ccnt_nxt;
	logic                busy_r;
	logic                busy_nxt;
	logic                start_r;
	logic                start_nxt;
	logic [RESULT_W-1:0] held_r;
	logic [RESULT_W-1:0] held_nxt;
	logic                link_clr_r;
	logic                link_clr_nxt;
	logic                convert_strobe_end;

	always_comb
	begin
		state_nxt = state_r;
		ccnt_nxt  = ccnt_r;
		busy_nxt  = busy_r;
		start_nxt = 1'b0;
		held_nxt  = held_r;
		convert_strobe_end  = 1'b0;
		case (state_r)
			asr_pkg::ASR_IDLE:
			begin
				if (strobe_fall)
				begin
					state_nxt = asr_pkg::ASR_CONVERT_STROBE;
					ccnt_nxt  = CONVERT_STROBE_LAST;
					busy_nxt  = !asr_pkg::BUSY_IDLE; // R3
					start_nxt = 1'b1;
				end
			end
			asr_pkg::ASR_CONVERT_STROBE:
			begin
				if (ccnt_r == '0)
				begin
					state_nxt = asr_pkg::ASR_IDLE;
					busy_nxt  = asr_pkg::BUSY_IDLE;
					convert_strobe_end  = 1'b1;
				end
				else
					ccnt_nxt = ccnt_r - 1'b1;
			end
			default:
			begin
				state_nxt = asr_pkg::ASR_IDLE;
				busy_nxt  = asr_pkg::BUSY_IDLE;
			end
		endcase
		buf_pop = convert_strobe_end;
		// held word changes only as busy rises, never under a read
		if (convert_strobe_end && buf_valid)
			held_nxt = buf_data; // R12
		// link side restarts on each busy edge; held in reset in master mode
		link_clr_nxt = !mode_slave || start_nxt || convert_strobe_end; // R10
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r    <= asr_pkg::ASR_IDLE;
			ccnt_r     <= '0;
			busy_r     <= asr_pkg::BUSY_IDLE;
			start_r    <= 1'b0;
			held_r     <= '0;
			link_clr_r <= 1'b1;
		end
		else
		begin
			state_r    <= state_nxt;
			ccnt_r     <= ccnt_nxt;
			busy_r     <= busy_nxt;
			start_r    <= start_nxt;
			held_r     <= held_nxt;
			link_clr_r <= link_clr_nxt;
		end
	end

	assign busy       = busy_r; // R2
	assign convert_strobe_start = start_r;

	// master shifter, clock derived from clk by a divider
	logic                msh_act_r;
	logic                msh_act_nxt;
	logic [RESULT_W-1:0] msh_word_r;
	logic [RESULT_W-1:0] msh_word_nxt;
	logic [BW-1:0]       msh_bit_r;
	logic [BW-1:0]       msh_bit_nxt;
	logic [PHW-1:0]      msh_ph_r;
	logic [PHW-1:0]      msh_ph_nxt;
	logic                sclk_r;
	logic                sclk_nxt;
	logic                mdata_r;
	logic                mdata_nxt;
	logic                sclk_oe_r;

	always_comb
	begin
		msh_act_nxt  = msh_act_r;
		msh_word_nxt = msh_word_r;
		msh_bit_nxt  = msh_bit_r;
		msh_ph_nxt   = msh_ph_r;
		mdata_nxt    = mdata_r;
		if (start_nxt && !mode_slave)
		begin
			// previous result goes out while this conversion runs
			msh_act_nxt  = 1'b1; // R3
			msh_word_nxt = held_r;
			msh_bit_nxt  = '0;
			msh_ph_nxt   = '0;
			mdata_nxt    = held_r[RESULT_W-1]; // R15
		end
		else if (msh_act_r)
		begin
			if (msh_ph_r == PH_LAST)
			begin
				msh_ph_nxt   = '0;
				msh_word_nxt = {msh_word_r[RESULT_W-2:0], 1'b0}; // R15
				msh_bit_nxt  = msh_bit_r + 1'b1;
				if (msh_bit_r == BIT_LAST)
				begin
					msh_act_nxt = 1'b0;
					// last bit held past the final fall for hold time
				end
			end
			else
				msh_ph_nxt = msh_ph_r + 1'b1;
			// change data mid low phase, clear of both clock edges
			if (msh_ph_nxt == PH_MID && msh_bit_nxt != '0 && msh_act_nxt)
				mdata_nxt = msh_word_r[RESULT_W-1]; // R4
		end
		sclk_nxt = msh_act_nxt && (msh_ph_nxt >= PH_HIGH); // R4
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			msh_act_r  <= 1'b0;
			msh_word_r <= '0;
			msh_bit_r  <= '0;
			msh_ph_r   <= '0;
			sclk_r     <= 1'b0;
			mdata_r    <= 1'b0;
			sclk_oe_r  <= 1'b0;
		end
		else
		begin
			msh_act_r  <= msh_act_nxt;
			msh_word_r <= msh_word_nxt;
			msh_bit_r  <= msh_bit_nxt;
			msh_ph_r   <= msh_ph_nxt;
			sclk_r     <= sclk_nxt;
			mdata_r    <= mdata_nxt;
			sclk_oe_r  <= !mode_slave; // R1
		end
	end

	assign sclk_o  = sclk_r;
	assign sclk_oe = sclk_oe_r;

	// slave shifter on the host clock; the host clock is static while
	// link_clr_r pulses, and held_r is steady for the whole read
	logic [BW-1:0] scnt_r;
	logic [BW-1:0] scnt_nxt;
	logic          sbit_r;
	logic          sbit_nxt;
	logic [BW-1:0] sidx;

	always_comb
	begin
		sidx     = BIT_LAST - scnt_r;
		scnt_nxt = scnt_r;
		sbit_nxt = 1'b0;
		// counting runs on across two byte transfers
		if (scnt_r != BIT_ALL)
		begin
			scnt_nxt = scnt_r + 1'b1; // R14
			sbit_nxt = held_r[sidx[BW-2:0]]; // R15
		end
	end

	// launch on rising edge; a 17th edge only drops the line low
	always_ff @(posedge sclk_i or posedge link_clr_r)
	begin
		if (link_clr_r)
		begin
			scnt_r <= '0;
			sbit_r <= 1'b0;
		end
		else
		begin
			scnt_r <= scnt_nxt; // R7
			sbit_r <= sbit_nxt; // R7
		end
	end

	// both sources are flops; the select is a quasi-static level
	assign serial_result_out = mode_slave ? sbit_r : mdata_r; // R1
endmodule // asr_result_port

//--- bench/asr_chk_properties.sv
// pin assertions for the serial result port
// bound to asr_result_port from the bench top file
`timescale 1ns/1ps
module asr_chk (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// pins
	input wire logic clock_source_select,
	input wire logic busy,
	input wire logic convert_strobe_start,
	input wire logic sclk_o,
	input wire logic sclk_oe,
	input wire logic serial_result_out
);
	logic [4:0] rise_r, rise_nxt;
	logic [2:0] up_r, up_nxt;
	logic       sclk_q_r;
	always_comb
	begin
		rise_nxt = busy ? 5'h00 : rise_r + 5'(sclk_o & ~sclk_q_r);
		up_nxt = up_r + 3'(up_r != 3'h7);
	end
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rise_r <= 5'h00;
			up_r <= 3'h0;
			sclk_q_r <= 1'b0;
		end
		else
		begin
			rise_r <= rise_nxt;
			up_r <= up_nxt;
			sclk_q_r <= sclk_o;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// select passes a synchroniser, so allow settling
	mode_select_a: assert property (
		$stable(clock_source_select)[*5] ##0 up_r == 3'h7
		|-> sclk_oe == !clock_source_select) else $error("sclk drive wrong");
	start_pulse_a: assert property (
		convert_strobe_start == $fell(busy)) else $error("start pulse wrong");
	first_clock_a: assert property (
		$fell(busy) && sclk_oe |-> !sclk_o ##2 sclk_o ##2 !sclk_o)
		else $error("serial clock not started");
	idle_low_a: assert property (
		busy |-> !sclk_o) else $error("sclk not idle low");
	data_hold_a: assert property (
		sclk_oe && $rose(sclk_o) |-> $stable(serial_result_out))
		else $error("data moved at sclk rise");
	data_fall_a: assert property (
		sclk_oe && $fell(sclk_o) |-> $stable(serial_result_out))
		else $error("data moved at sclk fall");
	bit_count_a: assert property (
		$rose(busy) && sclk_oe |-> rise_r == 5'h10)
		else $error("not 16 serial clocks");
endmodule // asr_chk

//--- bench/asr_host.sv
// host model: spi slave on busy/sclk_o, spi master on sclk_i
// bench calls xfer; sclk_i stands low outside frames
`timescale 1ns/1ps
module asr_host (
	// device pins
	input wire logic busy,
	input wire logic sclk_o,
	input wire logic serial_result_out,
	output logic     sclk_i
);
	logic [15:0] m_word;
	logic [4:0]  m_cnt;
	initial sclk_i = 1'b0;
	// busy serves as slave select, cpha 0 capture
	always @(negedge busy) m_cnt = 5'h00;
	always @(posedge sclk_o)
		if (!busy)
		begin
			m_word = {m_word[14:0], serial_result_out};
			m_cnt = m_cnt + 5'h01;
		end
	// 6 ns clock, sampled on falling edges
	task automatic xfer(input int n, output logic [15:0] w);
		w = 16'h0000;
		repeat (n)
		begin
			#3 sclk_i = 1'b1;
			#3 sclk_i = 1'b0;
			w = {w[14:0], serial_result_out};
		end
	endtask
	// rising-edge capture needs a 17th clock; first sample is idle 0
	task automatic xfer_rise(input int n, output logic [15:0] w);
		w = 16'h0000;
		repeat (n)
		begin
			#3 w = {w[14:0], serial_result_out};
			sclk_i = 1'b1;
			#3 sclk_i = 1'b0;
		end
	endtask
endmodule // asr_host

//--- bench/adc_serial_result_port_bench.sv
// self-checking bench for the serial result port
// package defaults; host model stands on the serial side
`timescale 1ns/1ps
module adc_serial_result_port_bench;
	logic        clk, sys_rst, rvalid, rready, sel, strobe_n, busy;
	logic        sdo, sclk_i, sclk_o, sclk_oe;
	logic [15:0] rdata, w;
	int          num_errors = 0;
	int          n_checks = 0;
	int          cyc = 0;
	localparam logic [15:0] W0 = 16'hA5C3;
	localparam logic [15:0] W1 = 16'h3C96;
	asr_result_port uut (.clk(clk), .sys_rst(sys_rst),
		.result_data(rdata), .result_valid(rvalid), .result_ready(rready),
		.convert_strobe_start(), .clock_source_select(sel),
		.convert_strobe_n(strobe_n), .busy(busy), .serial_result_out(sdo),
		.sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe(sclk_oe));
	asr_host host (.busy(busy), .sclk_o(sclk_o),
		.serial_result_out(sdo), .sclk_i(sclk_i));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic push(input logic [15:0] d);
		logic ok;
		@(posedge clk);
		rdata <= d;
		rvalid <= 1'b1;
		do
		begin
			@(negedge clk);
			ok = rready;
			@(posedge clk);
		end while (ok !== 1'b1);
		rvalid <= 1'b0;
	endtask
	// strobe released once busy has fallen
	task automatic convert_strobe();
		int n;
		n = 0;
		@(posedge clk);
		strobe_n <= 1'b0;
		@(negedge busy);
		strobe_n <= 1'b1;
		do
		begin
			@(negedge clk);
			n++;
		end while (busy === 1'b0);
		chk(16'(n - 1), 16'(asr_pkg::CONVERT_STROBE_CYCLES));
	endtask
	task automatic t_fill();
		push(W0);
		push(W1);
		@(negedge clk);
		chk(16'(rready), 16'h0000);
	endtask
	task automatic t_slave_bytes();
		convert_strobe();
		chk(16'(rready), 16'h0001);
		// host clock must stay static while the link side restarts
		repeat (2) @(negedge clk);
		host.xfer(8, w);
		chk(w, 16'(W0[15:8]));
		#50 host.xfer(8, w);
		chk(w, 16'(W0[7:0]));
	endtask
	task automatic t_master();
		@(posedge clk);
		sel <= 1'b0;
		repeat (5) @(posedge clk);
		chk(16'(sclk_oe), 16'h0001);
		convert_strobe();
		chk(host.m_word, W0);
		chk(16'(host.m_cnt), 16'h0010);
	endtask
	task automatic t_slave_full();
		@(posedge clk);
		sel <= 1'b1;
		repeat (5) @(posedge clk);
		chk(16'(sclk_oe), 16'h0000);
		host.xfer(16, w);
		chk(w, W1);
		host.xfer(1, w);
		chk(w, 16'h0000);
	endtask
	// read while converting returns the previous word
	task automatic t_during();
		@(posedge clk);
		strobe_n <= 1'b0;
		@(negedge busy);
		strobe_n <= 1'b1;
		repeat (2) @(negedge clk);
		host.xfer(16, w);
		chk(w, W1);
		chk(16'(busy), 16'h0000);
		@(posedge busy);
		repeat (2) @(negedge clk);
		host.xfer_rise(17, w);
		chk(w, W1);
	endtask
	initial
	begin
		sys_rst = 1'b1;
		sel = 1'b1;
		strobe_n = 1'b1;
		rvalid = 1'b0;
		rdata = 16'h0000;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(16'(busy), 16'h0001);
		chk(16'(sclk_o), 16'h0000);
		t_fill();
		t_slave_bytes();
		t_master();
		t_slave_full();
		t_during();
		wrap_up();
	end
endmodule // adc_serial_result_port_bench
bind asr_result_port asr_chk chk_i (.clk(clk), .sys_rst(sys_rst),
	.clock_source_select(clock_source_select), .busy(busy),
	.convert_strobe_start(convert_strobe_start), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
	.serial_result_out(serial_result_out));
